/* bench/core_model.sv */
// processor core model: instruction pulses and request acknowledge
`timescale 1ns/10ps
module core_model
	import irq_edge_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire cpu_req_t req_i,
	input wire logic [2:0] cmd_i,
	input wire logic auto_ack_i,
	output cpu_evt_t evt_o
);
	logic seen_reg;
	// one-cycle events, a single acknowledge per raised request;
	// seen holds from the acknowledge until the request drops
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			evt_o <= '0;
			seen_reg <= 1'b0;
		end else begin
			evt_o.enable_interrupts_instruction <= cmd_i[2];
			evt_o.interrupt_return_instruction <= cmd_i[1];
			evt_o.disable_interrupts_instruction <= cmd_i[0];
			evt_o.ack <= auto_ack_i & req_i.req & ~seen_reg;
			seen_reg <= req_i.req & (seen_reg | auto_ack_i);
		end
	end
endmodule

/* bench/irq_edge_ctrl_bench.sv */
// bench for edge select, shared select and master enable
`timescale 1ns/10ps
module irq_edge_ctrl_bench
	import irq_edge_pkg::*;
;
	typedef struct packed {
		logic [7:0] sel, pol, a0, a1;
		logic [1:0] s0, s1;
		logic [7:0] exp;
	} row_t;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic auto_ack = 1'b0;
	logic [2:0] cmd = 3'h0;
	logic [7:0] q;
	int fail_count = 0;
	int check_count = 0;
	wb_req_t req = '0;
	wb_rsp_t rsp;
	cpu_evt_t evt;
	irq_src_t src = '0;
	cpu_req_t creq;
	logic irq;
	logic [IDX_W-1:0] ids[4] = '{IDX_EDGE_POL, IDX_SHARED, IDX_MASTER,
		14'h0fd8};
	// select, polarity, port start/end, side sources start/end, status
	row_t rows[8] = '{
		'{8'h00, 8'hff, 8'h00, 8'hff, 2'h0, 2'h0, 8'hff},
		'{8'h00, 8'h00, 8'hff, 8'h00, 2'h0, 2'h0, 8'hff},
		'{8'h00, 8'h0f, 8'h00, 8'hff, 2'h0, 2'h0, 8'h0f},
		'{8'h00, 8'h0f, 8'hff, 8'h00, 2'h0, 2'h0, 8'hf0},
		'{8'h80, 8'h80, 8'h00, 8'h80, 2'h0, 2'h0, 8'h00},
		'{8'h80, 8'h80, 8'h80, 8'h80, 2'h0, 2'h2, 8'h80},
		'{8'h40, 8'h00, 8'h00, 8'h00, 2'h1, 2'h0, 8'h40},
		'{8'h40, 8'h40, 8'h00, 8'h40, 2'h0, 2'h0, 8'h00}};

	// 10 MHz clock
	always #50 mclk_i = ~mclk_i;

	irq_edge_ctrl u_dut(.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_req_i(req),
		.wb_rsp_o(rsp), .cpu_evt_i(evt), .src_i(src), .cpu_req_o(creq),
		.irq_o(irq));
	core_model u_core(.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(creq),
		.cmd_i(cmd), .auto_ack_i(auto_ack), .evt_o(evt));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk_i);
	endtask

	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [IDX_W-1:0] i,
		input logic [7:0] d);
		int n;
		n = 0;
		req <= '{1'b1, 1'b1, w, 4'h1, {i, 2'h0}, {24'h0, d}};
		do begin
			@(posedge mclk_i);
			n++;
		end while (rsp.ack !== 1'b1 && n < 20);
		q = rsp.dat[7:0];
		req <= '0;
		@(posedge mclk_i);
		if (n >= 20) begin
			fail_count++;
			end_sim();
		end
	endtask

	task automatic pulse(input logic [2:0] c);
		cmd <= c;
		tick(1);
		cmd <= 3'h0;
		tick(3);
	endtask

	initial begin
		tick(8);
		nrst_i <= 1'b1;
		tick(3);
		foreach (rows[k]) begin
			wb(1'b1, IDX_SHARED, rows[k].sel);
			wb(1'b1, IDX_EDGE_POL, rows[k].pol);
			src <= {rows[k].a0, rows[k].s0};
			tick(8);
			wb(1'b0, IDX_STATUS, 8'h00);
			src <= {rows[k].a1, rows[k].s1};
			tick(8);
			wb(1'b0, IDX_STATUS, 8'h00);
			chk(q, rows[k].exp);
		end
		$display("test edge rows done");
		// switching the shared source, masking and read-clear
		wb(1'b1, IDX_SHARED, 8'h00);
		wb(1'b1, IDX_EDGE_POL, 8'h80);
		src <= {8'h00, 2'h2};
		tick(8);
		wb(1'b0, IDX_STATUS, 8'h00);
		wb(1'b1, IDX_SHARED, 8'h80);
		tick(8);
		chk({7'h0, irq}, 8'h00);
		wb(1'b1, IDX_MASK, 8'h80);
		chk({7'h0, irq}, 8'h01);
		wb(1'b0, IDX_STATUS, 8'h00);
		chk(q, 8'h80);
		chk({7'h0, irq}, 8'h00);
		$display("test shared switch done");
		// master enable gating, instructions and core acknowledge
		wb(1'b1, IDX_EN_HIGH, 8'h02);
		wb(1'b1, IDX_EDGE_POL, 8'h02);
		wb(1'b1, IDX_MASTER, 8'h80);
		wb(1'b0, IDX_MASTER, 8'h00);
		chk(q, 8'h80);
		src <= {8'h02, 2'h0};
		tick(8);
		chk({6'h0, creq.level}, {6'h0, PRI_MED});
		chk({5'h0, creq.line}, 8'h01);
		chk({7'h0, creq.req}, 8'h01);
		wb(1'b1, IDX_MASTER, 8'h00);
		chk({7'h0, creq.req}, 8'h00);
		pulse(3'h4);
		chk({7'h0, creq.req}, 8'h01);
		auto_ack <= 1'b1;
		tick(4);
		wb(1'b0, IDX_MASTER, 8'h00);
		chk(q, 8'h00);
		pulse(3'h2);
		wb(1'b0, IDX_MASTER, 8'h00);
		chk(q, 8'h80);
		pulse(3'h1);
		wb(1'b0, IDX_MASTER, 8'h00);
		chk(q, 8'h00);
		$display("test master enable done");
		// second reset in mid-run, then reset values and unmapped index
		wb(1'b1, IDX_MASTER, 8'h80);
		nrst_i <= 1'b0;
		tick(3);
		nrst_i <= 1'b1;
		tick(3);
		foreach (ids[k]) begin
			wb(1'b0, ids[k], 8'h00);
			chk(q, 8'h00);
		end
		$display("test reset values done");
		end_sim();
	end
endmodule

/* verilog/irq_edge_ctrl.sv */
// edge select, shared source select and master enable with wishbone slave
// What this block does
// - polarity bit 0 falling, 1 rising edge
// - select bit 7 picks port bit 7 or detector
// - select bit 6 picks port bit 6 or comparator
// - shared requests edge-triggered, switching may fire
// - master enable 0 blocks core requests, not irq_o
// - enable set by enable, return instruction, write one
// - cleared by disable instruction, ack, reset, write zero
// - high and low enable give three priorities and off
`timescale 1ns/10ps
module irq_edge_ctrl
	import irq_edge_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire wb_req_t wb_req_i,
	output wb_rsp_t wb_rsp_o,
	input wire cpu_evt_t cpu_evt_i,
	input wire irq_src_t src_i,
	output cpu_req_t cpu_req_o,
	output logic irq_o
);
	typedef struct packed {
		logic [REG_W-1:0] en_high;
		logic [REG_W-1:0] en_low;
		logic [REG_W-1:0] edge_pol;
		logic [REG_W-1:0] shared_sel;
		logic master_en;
		logic [REG_W-1:0] status;
		logic [REG_W-1:0] mask;
		logic ack;
		logic [DAT_W-1:0] rdat;
		logic irq;
		logic cpu_irq;
		priority_t pri_level;
		logic [LINE_IDX_W-1:0] pri_line;
	} ctl_state_t;

	logic [1:0] rst_sync_reg;
	logic rst_n;
	ctl_state_t st_reg;
	ctl_state_t st_next;
	logic [LINE_N-1:0] line_src;
	logic [LINE_N-1:0] ev_pulse;
	logic [IDX_W-1:0] idx;
	logic bus_req;
	logic do_access;
	logic do_write;
	logic do_read;
	logic wr_master;
	logic [REG_W-1:0] wbyte;
	logic en_evt;
	logic dis_evt;

	// reset release through two flops
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_reg <= RST_SYNC;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// shared line routing ahead of the detector
	always_comb begin
		line_src = src_i.port_a;
		if (st_reg.shared_sel[BIT_VOLTAGE_SHARE]) begin
			line_src[BIT_VOLTAGE_SHARE] =
				src_i.low_voltage_detector;
		end
		if (st_reg.shared_sel[BIT_SHARE_CMP]) begin
			line_src[BIT_SHARE_CMP] = src_i.comparator;
		end
	end

	// a switch of source passes through the same edge path
	irq_edge_detect u_detect (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.sig_i(line_src),
		.pol_i(st_reg.edge_pol),
		.pulse_o(ev_pulse)
	);

	// bus decode, access takes effect on the acked edge
	assign idx = wb_req_i.adr[ADR_W-1:2];
	assign bus_req = wb_req_i.cyc && wb_req_i.stb;
	assign do_access = bus_req && st_reg.ack;
	assign do_write = do_access && wb_req_i.we && wb_req_i.sel[LANE_LOW];
	assign do_read = do_access && !wb_req_i.we;
	assign wbyte = wb_req_i.dat[REG_W-1:0];
	assign wr_master = do_write && (idx == IDX_MASTER);

	// core events that move the master enable
	assign en_evt = cpu_evt_i.enable_interrupts_instruction ||
		cpu_evt_i.interrupt_return_instruction;
	assign dis_evt = cpu_evt_i.disable_interrupts_instruction ||
		cpu_evt_i.ack;

	// read data for an index, unmapped reads zero
	function automatic logic [DAT_W-1:0] read_word(
		input logic [IDX_W-1:0] i,
		input ctl_state_t s
	);
		logic [REG_W-1:0] b;
		b = RST_BYTE;
		unique case (i)
			IDX_EN_HIGH: b = s.en_high;
			IDX_EN_LOW: b = s.en_low;
			IDX_EDGE_POL: b = s.edge_pol;
			IDX_SHARED: b = s.shared_sel;
			IDX_MASTER: b[BIT_MASTER_EN] = s.master_en;
			IDX_STATUS: b = s.status;
			IDX_MASK: b = s.mask;
			default: b = RST_BYTE;
		endcase
		return {{(DAT_W-REG_W){1'b0}}, b};
	endfunction

	// next state of the whole block
	always_comb begin
		logic [REG_W-1:0] clr;
		logic found;
		st_next = st_reg;
		clr = RST_BYTE;
		found = 1'b0;
		// wishbone handshake, ack one cycle then drop
		st_next.ack = bus_req && !st_reg.ack;
		if (bus_req && !st_reg.ack) begin
			st_next.rdat = read_word(idx, st_reg);
		end else if (st_reg.ack) begin
			st_next.rdat = RST_WORD;
		end
		// plain read-write configuration registers
		if (do_write) begin
			unique case (idx)
				IDX_EN_HIGH: st_next.en_high = wbyte;
				IDX_EN_LOW: st_next.en_low = wbyte;
				IDX_EDGE_POL: st_next.edge_pol = wbyte;
				IDX_SHARED: st_next.shared_sel = wbyte;
				IDX_MASK: st_next.mask = wbyte;
				default: st_next.mask = st_reg.mask;
			endcase
		end
		// master enable, disable and ack win over enable events, events win over a write
		if (wr_master) begin
			st_next.master_en = wbyte[BIT_MASTER_EN];
		end
		if (en_evt) begin
			st_next.master_en = 1'b1;
		end
		if (dis_evt) begin
			st_next.master_en = 1'b0;
		end
		// sticky requests, a read clears only the bits it returned
		// so an edge caught during the read is not lost
		if (do_read && idx == IDX_STATUS) begin
			clr = st_reg.rdat[REG_W-1:0];
		end
		if (cpu_evt_i.ack && st_reg.cpu_irq) begin
			clr[st_reg.pri_line] = 1'b1;
		end
		st_next.status = (st_reg.status & ~clr) | ev_pulse;
		// highest pending level, lowest line on a tie
		st_next.pri_level = PRI_OFF;
		st_next.pri_line = RST_LINE;
		for (int i = LINE_N - 1; i >= 0; i--) begin
			if (st_next.status[i] &&
				{st_next.en_high[i], st_next.en_low[i]} != PRI_OFF &&
				priority_t'({st_next.en_high[i], st_next.en_low[i]})
				>= st_next.pri_level) begin
				st_next.pri_level = priority_t'({st_next.en_high[i],
					st_next.en_low[i]});
				st_next.pri_line = LINE_IDX_W'(i);
				found = 1'b1;
			end
		end
		st_next.cpu_irq = found && st_next.master_en;
		st_next.irq = |(st_next.status & st_next.mask);
	end

	// single register bank of the block
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops
	assign wb_rsp_o.ack = st_reg.ack;
	assign wb_rsp_o.dat = st_reg.rdat;
	assign cpu_req_o.req = st_reg.cpu_irq;
	assign cpu_req_o.level = st_reg.pri_level;
	assign cpu_req_o.line = st_reg.pri_line;
	assign irq_o = st_reg.irq;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	// master enable behaviour
	enable_set_a: assert property (en_evt && !dis_evt |=>
		st_reg.master_en)
		else $error("enable instruction did not set master enable");
	enable_clear_a: assert property (dis_evt |=>
		!st_reg.master_en && !cpu_req_o.req)
		else $error("disable event did not clear master enable");
	enable_write_a: assert property (wr_master && !dis_evt &&
		!en_evt
		|=> st_reg.master_en == $past(wbyte[BIT_MASTER_EN]))
		else $error("write to master enable not stored");
	master_gate_a: assert property (!st_reg.master_en |->
		!cpu_req_o.req)
		else $error("request reached core while disabled");

	// source routing and request capture
	share_voltage_a: assert property (
		st_reg.shared_sel[BIT_VOLTAGE_SHARE] |->
		line_src[BIT_VOLTAGE_SHARE] == src_i.low_voltage_detector)
		else $error("line 7 not routed from detector");
	share_cmp_a: assert property (!st_reg.shared_sel[BIT_SHARE_CMP] |->
		line_src[BIT_SHARE_CMP] == src_i.port_a[BIT_SHARE_CMP])
		else $error("line 6 not routed from port");
	sticky_set_a: assert property (ev_pulse[0] |=>
		st_reg.status[0])
		else $error("edge pulse lost against clear");
	sticky_cause_a: assert property ($rose(st_reg.status[0]) |->
		$past(ev_pulse[0]))
		else $error("request set without an edge");
	unread_kept_a: assert property (do_read && !cpu_evt_i.ack &&
		idx == IDX_STATUS |=> ($past(st_reg.status) &
		~$past(st_reg.rdat[REG_W-1:0]) & ~st_reg.status) == '0)
		else $error("unreported request lost by status read");

	// priority and bus answers
	pri_match_a: assert property (cpu_req_o.req |->
		cpu_req_o.level != PRI_OFF && cpu_req_o.level ==
		{st_reg.en_high[cpu_req_o.line], st_reg.en_low[cpu_req_o.line]})
		else $error("priority level does not match line");
	ack_once_a: assert property (bus_req && !wb_rsp_o.ack |=>
		wb_rsp_o.ack ##1 !wb_rsp_o.ack)
		else $error("ack not a single cycle");
	reserved_zero_a: assert property (wb_rsp_o.ack && !wb_req_i.we &&
		idx == IDX_MASTER |-> wb_rsp_o.dat[BIT_MASTER_EN-1:0] == '0)
		else $error("reserved control bits read non-zero");

	// main scenarios
	enable_rise_c: cover property ($rose(st_reg.master_en));
	spurious_c: cover property (
		$changed(st_reg.shared_sel[BIT_VOLTAGE_SHARE])
		##[1:4] ev_pulse[BIT_VOLTAGE_SHARE]);
	high_req_c: cover property (cpu_req_o.req &&
		cpu_req_o.level == PRI_HIGH);
	read_clear_c: cover property (do_read && idx == IDX_STATUS &&
		st_reg.status != '0 ##1 st_reg.status == '0);
endmodule

/* verilog/irq_edge_detect.sv */
// synchroniser and polarity-selected edge detector for the request lines
`timescale 1ns/10ps
module irq_edge_detect
	import irq_edge_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [LINE_N-1:0] sig_i,
	input wire logic [LINE_N-1:0] pol_i,
	output logic [LINE_N-1:0] pulse_o
);
	typedef struct packed {
		logic [LINE_N-1:0] s1;
		logic [LINE_N-1:0] s2;
		logic [LINE_N-1:0] prev;
		logic [LINE_N-1:0] pulse;
	} det_state_t;

	det_state_t st_reg;
	det_state_t st_next;

	// sync chain, previous copy, one-cycle pulse on the chosen edge
	always_comb begin
		st_next = st_reg;
		st_next.s1 = sig_i;
		st_next.s2 = st_reg.s1;
		st_next.prev = st_reg.s2;
		st_next.pulse = (pol_i & st_reg.s2 & ~st_reg.prev) |
			(~pol_i & ~st_reg.s2 & st_reg.prev);
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pulse_o = st_reg.pulse;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	rise_pulse_a: assert property ($rose(sig_i[0]) ##1
		(pol_i[0] && $stable(sig_i[0]))[*2] |-> ##1 pulse_o[0])
		else $error("rising edge gave no request");
	fall_pulse_a: assert property ($fell(sig_i[0]) ##1
		(!pol_i[0] && $stable(sig_i[0]))[*2] |-> ##1 pulse_o[0])
		else $error("falling edge gave no request");
	pulse_cause_a: assert property (pulse_o[0] |->
		$past(sig_i[0], 3) != $past(sig_i[0], 4) ##1 !pulse_o[0])
		else $error("request pulse without edge or too long");
endmodule

/* verilog/irq_edge_pkg.sv */
// shared constants and carrier types of the edge and master-enable block
package irq_edge_pkg;
	// bus geometry
	localparam int ADR_W = 16;
	localparam int DAT_W = 32;
	localparam int IDX_W = 14;
	localparam int REG_W = 8;
	localparam int LINE_N = 8;
	localparam int LINE_IDX_W = 3;

	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_EN_HIGH = 14'h0fc4;
	localparam logic [IDX_W-1:0] IDX_EN_LOW = 14'h0fc5;
	localparam logic [IDX_W-1:0] IDX_EDGE_POL = 14'h0fcd;
	localparam logic [IDX_W-1:0] IDX_SHARED = 14'h0fce;
	localparam logic [IDX_W-1:0] IDX_MASTER = 14'h0fcf;
	localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0fd0;
	localparam logic [IDX_W-1:0] IDX_MASK = 14'h0fd1;

	// field positions
	localparam int BIT_MASTER_EN = 7;
	localparam int BIT_VOLTAGE_SHARE = 7;
	localparam int BIT_SHARE_CMP = 6;
	localparam int LANE_LOW = 0;

	// reset values
	localparam logic [REG_W-1:0] RST_BYTE = 8'h00;
	localparam logic [DAT_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [LINE_IDX_W-1:0] RST_LINE = 3'h0;
	localparam logic [1:0] RST_SYNC = 2'h0;

	// priority levels of a request line, high and low enable bits
	typedef enum logic [1:0] {
		PRI_OFF,
		PRI_LOW,
		PRI_MED,
		PRI_HIGH
	} priority_t;

	// classic wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [DAT_W-1:0] dat;
	} wb_req_t;

	// wishbone answer of the slave
	typedef struct packed {
		logic ack;
		logic [DAT_W-1:0] dat;
	} wb_rsp_t;

	// one-cycle instruction events from the processor core
	typedef struct packed {
		logic enable_interrupts_instruction;
		logic interrupt_return_instruction;
		logic disable_interrupts_instruction;
		logic ack;
	} cpu_evt_t;

	// raw interrupt sources
	typedef struct packed {
		logic [LINE_N-1:0] port_a;
		logic low_voltage_detector;
		logic comparator;
	} irq_src_t;

	// request toward the processor core
	typedef struct packed {
		logic req;
		priority_t level;
		logic [LINE_IDX_W-1:0] line;
	} cpu_req_t;
endpackage
